// file: lrpcu_pkg.sv
// Package for the LCD RAM pointer command unit: command codes, field positions, timing.
// Assumes a single 100 MHz mclk domain and a host bus sampled through synchronisers.
package lrpcu_pkg;
    localparam int LRPCU_CLK_MHZ = 100;
    localparam logic [7:0] LRPCU_CMD_START_LO = 8'h08;
    localparam logic [7:0] LRPCU_CMD_START_HI = 8'h09;
    localparam logic [7:0] LRPCU_CMD_PTR_LO = 8'h0a;
    localparam logic [7:0] LRPCU_CMD_PTR_HI = 8'h0b;
    localparam logic [7:0] LRPCU_CMD_RAM_WRITE = 8'h0c;
    localparam logic [7:0] LRPCU_CMD_RAM_READ = 8'h0d;
    localparam logic [7:0] LRPCU_CMD_BIT_ZERO = 8'h0e;
    localparam logic [7:0] LRPCU_CMD_BIT_ONE = 8'h0f;
    localparam logic [7:0] LRPCU_CMD_LAST = 8'h0f;
    localparam int LRPCU_BUSY_BIT = 7;
    localparam int LRPCU_INDEX_W = 3;
    localparam logic [7:0] LRPCU_CMD_RESET = 8'h00;
    localparam logic [15:0] LRPCU_ADDR_RESET = 16'h0000;
    localparam logic [7:0] LRPCU_DATA_RESET = 8'h00;
    // Busy time of a parameter command in ns, and its cycle count (rounded up)
    localparam int LRPCU_BUSY_NS = 40;
    localparam int LRPCU_BUSY_CYC = (LRPCU_BUSY_NS * LRPCU_CLK_MHZ + 999) / 1000;
    typedef enum logic [4:0] {
        LRPCU_IDLE = 5'b00001,
        LRPCU_EXEC = 5'b00010,
        LRPCU_RMW_RD = 5'b00100,
        LRPCU_RMW_WR = 5'b01000,
        LRPCU_FETCH = 5'b10000
    } lrpcu_state_t;
endpackage

// file: lrpcu_ram_if.sv
// Interface carrying display RAM requests between the command unit and its RAM.
// Assumes one clock; read data is valid the cycle after a read request.
interface lrpcu_ram_if #(parameter int AW = 15);
    logic [AW-1:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
    modport mem (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// file: lrpcu_ram.sv
// Display RAM, single port, synchronous read.
// Assumes it is driven by the command unit over lrpcu_ram_if.
module lrpcu_ram #(
    parameter int AW = 15
) (
    input wire logic mclk,    // System clock
    lrpcu_ram_if.mem bus      // RAM request port
);
    logic [7:0] mem_q [0:(1<<AW)-1];
    logic [7:0] rd_q;
    always_ff @(posedge mclk) begin
        if (bus.wr_en) begin
            mem_q[bus.addr] <= bus.wr_data;
        end
        rd_q <= mem_q[bus.addr];
    end
    assign bus.rd_data = rd_q;
endmodule

// file: lrpcu_top.sv
// Host port of a dot-matrix LCD controller: command select, start and pointer
// registers, display RAM data access, bit clear and set, busy reporting.
// Assumes an asynchronous host bus: strobe, register select, direction and data
// are sampled through two flip-flops before use.

// Function
// - After command cmd_ram_write, data writes store the byte at the pointer.
// - Each display data write advances the pointer by one.
// - A 16-bit view origin is held, loaded as lower and upper byte.
// - Pointer lower and upper commands load the matching pointer half.
// - All RAM reads, writes and bit operations address RAM by the pointer.
// - The pointer consists of separately loaded lower and upper bytes.
// - In character mode the cursor is shown at the pointer position.
// - Pointer is a loadable 16-bit up-counter carrying from low to high byte.
// - Data reads return the holding register, then refill it and advance.
// - Bit clear forces one RAM bit to 0, bit set forces it to 1.
// - Bit index is written as the bit number itself in the low three bits.
// - Completing a bit clear or set advances the pointer by one.
// - Register-select-high reads return busy on bus bit 7.
// - Busy reads 1 while a parameter command executes, 0 when done.
// - While busy, further commands and data transfers are ignored.
// - Writing the command select register does not raise busy.
// - Busy is readable at any time without selecting a command.
// - Register select high addresses command select, low the parameter or data.
module lrpcu_top import lrpcu_pkg::*; #(
    parameter int AW = 15,
    parameter int BUSY_CYC = LRPCU_BUSY_CYC
) (
    input wire logic mclk,                 // System clock
    input wire logic reset,                // Synchronous reset, active high
    input wire logic host_strobe,          // Host access strobe, high during an access
    input wire logic register_select_line, // High: command or busy, low: data
    input wire logic host_read,            // High for a read, low for a write
    input wire logic [7:0] host_data_in,   // Data bus driven by the host
    output logic [7:0] host_data_out,      // Data bus driven to the host
    output logic host_data_oe,             // High while the unit drives the bus
    input wire logic char_mode,            // High in character display mode
    output logic [15:0] view_origin,       // Start address for display refresh
    output logic [15:0] cursor_addr,       // Cursor position for display refresh
    output logic busy                      // Busy indicator
);
    logic [2:0] stb_s1_q, stb_s2_q;
    logic [7:0] dat_s1_q, dat_s2_q;
    logic stb_prev_q;
    logic [7:0] cmd_q;
    logic [15:0] origin_q;
    logic [15:0] ptr_q;
    logic [7:0] hold_q;
    logic [7:0] out_q;
    logic oe_q;
    logic [7:0] bit_idx_q;
    logic bit_val_q;
    logic [7:0] wdata_q;
    localparam int CNT_W = $clog2(BUSY_CYC + 1) + 1;
    logic [CNT_W-1:0] cnt_q;
    lrpcu_state_t state_q;
    lrpcu_ram_if #(.AW(AW)) ram_bus ();

    lrpcu_ram #(.AW(AW)) u_ram (
        .mclk(mclk),
        .bus(ram_bus)
    );

    function automatic logic [7:0] lrpcu_bit_mask(input logic [2:0] idx);
        lrpcu_bit_mask = 8'h01 << idx;
    endfunction

    // Synchronised host signals: strobe, select, direction
    always_ff @(posedge mclk) begin
        stb_s1_q <= {host_strobe, register_select_line, host_read};
        stb_s2_q <= stb_s1_q;
        dat_s1_q <= host_data_in;
        dat_s2_q <= dat_s1_q;
    end

    wire stb = stb_s2_q[2];
    wire rs = stb_s2_q[1];
    wire rd = stb_s2_q[0];
    wire [7:0] din = dat_s2_q;
    // Access taken on the rising edge of the synchronised strobe
    wire access = stb && !stb_prev_q;
    wire idle = (state_q == LRPCU_IDLE);
    // A command select write during execution would change the running command
    wire cmd_wr = access && rs && !rd && idle;
    wire stat_rd = access && rs && rd;
    wire data_acc = access && !rs && idle;
    wire data_wr = data_acc && !rd;
    wire data_rd = data_acc && rd;
    wire is_ram_wr = (cmd_q == LRPCU_CMD_RAM_WRITE);
    wire is_ram_rd = (cmd_q == LRPCU_CMD_RAM_READ);
    wire is_bit_op = (cmd_q == LRPCU_CMD_BIT_ZERO) || (cmd_q == LRPCU_CMD_BIT_ONE);
    wire known_cmd = (cmd_q <= LRPCU_CMD_LAST);
    wire [15:0] ptr_inc = ptr_q + 16'h0001;
    wire [7:0] mask = lrpcu_bit_mask(bit_idx_q[LRPCU_INDEX_W-1:0]);
    wire [7:0] rmw_data = bit_val_q ? (ram_bus.rd_data | mask) : (ram_bus.rd_data & ~mask);

    // RAM port: every access uses the pointer
    assign ram_bus.addr = ptr_q[AW-1:0];
    assign ram_bus.wr_en = (state_q == LRPCU_EXEC && is_ram_wr) || (state_q == LRPCU_RMW_WR);
    assign ram_bus.wr_data = (state_q == LRPCU_RMW_WR) ? rmw_data : wdata_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            stb_prev_q <= 1'b0;
            cmd_q <= LRPCU_CMD_RESET;
            origin_q <= LRPCU_ADDR_RESET;
            ptr_q <= LRPCU_ADDR_RESET;
            hold_q <= LRPCU_DATA_RESET;
            out_q <= LRPCU_DATA_RESET;
            oe_q <= 1'b0;
            bit_idx_q <= LRPCU_DATA_RESET;
            bit_val_q <= 1'b0;
            wdata_q <= LRPCU_DATA_RESET;
            cnt_q <= '0;
            state_q <= LRPCU_IDLE;
        end else begin
            stb_prev_q <= stb;
            oe_q <= stb && rd;
            // Command select write leaves busy untouched
            if (cmd_wr) begin
                cmd_q <= din;
            end
            if (stat_rd) begin
                out_q <= {busy, 7'h00};
            end
            case (state_q)
                LRPCU_IDLE: begin
                    if (data_wr && known_cmd) begin
                        wdata_q <= din;
                        cnt_q <= '0;
                        state_q <= LRPCU_EXEC;
                        if (cmd_q == LRPCU_CMD_START_LO) begin
                            origin_q[7:0] <= din;
                        end else if (cmd_q == LRPCU_CMD_START_HI) begin
                            origin_q[15:8] <= din;
                        end else if (cmd_q == LRPCU_CMD_PTR_LO) begin
                            ptr_q[7:0] <= din;
                        end else if (cmd_q == LRPCU_CMD_PTR_HI) begin
                            ptr_q[15:8] <= din;
                        end else if (is_bit_op) begin
                            bit_idx_q <= din;
                            bit_val_q <= (cmd_q == LRPCU_CMD_BIT_ONE);
                            state_q <= LRPCU_RMW_RD;
                        end
                    end else if (data_rd && is_ram_rd) begin
                        // Old holding contents go out first, then refill
                        out_q <= hold_q;
                        state_q <= LRPCU_FETCH;
                    end
                end
                LRPCU_EXEC: begin
                    if (is_ram_wr) begin
                        ptr_q <= ptr_inc;
                        state_q <= LRPCU_IDLE;
                    end else if (cnt_q >= CNT_W'(BUSY_CYC - 1)) begin
                        state_q <= LRPCU_IDLE;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                LRPCU_RMW_RD: begin
                    state_q <= LRPCU_RMW_WR;
                end
                LRPCU_RMW_WR: begin
                    ptr_q <= ptr_inc;
                    state_q <= LRPCU_IDLE;
                end
                LRPCU_FETCH: begin
                    // RAM data arrives the cycle after the address settles
                    hold_q <= ram_bus.rd_data;
                    ptr_q <= ptr_inc;
                    state_q <= LRPCU_IDLE;
                end
                default: begin
                    state_q <= LRPCU_IDLE;
                end
            endcase
        end
    end

    assign busy = !idle;
    assign host_data_out = out_q;
    assign host_data_oe = oe_q;
    assign view_origin = origin_q;
    // Refresh logic places the cursor here only in character mode
    assign cursor_addr = char_mode ? ptr_q : 16'h0000;
endmodule

// file: lrpcu_checker.sv
// Port-level assertions for the LCD RAM pointer command unit.
// Assumes it is bound to lrpcu_top and sees only its ports.
module lrpcu_checker #(
    parameter int BUSY_CYC = 4
) (
    input wire logic mclk, // Clock
    input wire logic reset, // Sync reset
    input wire logic host_strobe, // Strobe
    input wire logic register_select_line, // Select
    input wire logic host_read, // Direction
    input wire logic [7:0] host_data_in, // Host data
    input wire logic [7:0] host_data_out, // Read data
    input wire logic host_data_oe, // Bus enable
    input wire logic char_mode, // Character mode
    input wire logic [15:0] view_origin, // Start address
    input wire logic [15:0] cursor_addr, // Cursor
    input wire logic busy // Busy
);
    localparam int BUSY_MAX = BUSY_CYC + 4;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence busy_start;
        $rose(busy);
    endsequence
    sequence read_start;
        $rose(host_strobe) && host_read;
    endsequence
    busy_bound_a: assert property (busy_start |-> ##[1:BUSY_MAX] !busy)
        else $error("busy held too long");
    data_busy_a: assert property (busy_start |-> host_strobe && !register_select_line)
        else $error("busy raised without a data access");
    read_answer_a: assert property (read_start |-> ##[2:4] host_data_oe)
        else $error("read not answered");
    oe_cause_a: assert property (host_data_oe |-> host_read)
        else $error("bus driven outside a read");
    status_bits_a: assert property ($fell(host_strobe) && register_select_line && host_read
        |-> host_data_out[6:0] == 7'h00) else $error("status low bits not zero");
    origin_hold_a: assert property (!busy && $past(!busy) |-> $stable(view_origin))
        else $error("start address changed while idle");
    cursor_hold_a: assert property (!busy && $past(!busy) && char_mode && $past(char_mode)
        |-> $stable(cursor_addr)) else $error("cursor changed while idle");
    cursor_hidden_a: assert property (!char_mode |-> cursor_addr == 16'h0000)
        else $error("cursor shown outside character mode");
endmodule

bind lrpcu_top lrpcu_checker #(.BUSY_CYC(BUSY_CYC)) i_checker (.mclk, .reset, .host_strobe,
    .register_select_line, .host_read, .host_data_in, .host_data_out, .host_data_oe, .char_mode,
    .view_origin, .cursor_addr, .busy);

// file: lrpcu_host.sv
// Host microprocessor model: strobed bus cycles and busy polling.
// Assumes the unit answers within six cycles of the strobe rising.
module lrpcu_host (
    input wire logic mclk, // Clock
    output logic host_strobe, // Strobe
    output logic register_select_line, // Select
    output logic host_read, // Direction
    output logic [7:0] host_data_in, // Host data
    input wire logic [7:0] host_data_out // Read data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        host_strobe = 1'b0;
        register_select_line = 1'b1;
        host_read = 1'b1;
        host_data_in = 8'h00;
    end
    task automatic access(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        #1;
        register_select_line = rs;
        host_read = rd;
        host_data_in = d;
        host_strobe = 1'b1;
        repeat (6) @(posedge mclk);
        q = host_data_out;
        #1;
        host_strobe = 1'b0;
        host_data_in = ~d; // Released bus must not show the old byte
        repeat (4) @(posedge mclk);
    endtask
    task automatic wait_ready();
        logic [7:0] s;
        s = 8'h80;
        for (int i = 0; i < 20 && s[7] !== 1'b0; i++) begin
            access(1'b1, 1'b1, 8'h00, s);
        end
    endtask
endmodule

// file: lcd_ram_pointer_command_unit_tb.sv
// Self-checking bench for lrpcu_top, driven through the host model.
// Assumes the package and design files are compiled first.
module lcd_ram_pointer_command_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, reset, host_strobe, register_select_line, host_read, char_mode, busy;
    logic [7:0] host_data_in, host_data_out, q;
    logic [15:0] view_origin, cursor_addr;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    lrpcu_top #(.BUSY_CYC(40)) i_dut (.mclk, .reset, .host_strobe, .register_select_line, .host_read,
        .host_data_in, .host_data_out, .host_data_oe(), .char_mode, .view_origin, .cursor_addr, .busy(busy));
    lrpcu_host i_host (.mclk, .host_strobe, .register_select_line, .host_read, .host_data_in, .host_data_out);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic sel, input logic [7:0] d);
        i_host.wait_ready();
        i_host.access(sel, 1'b0, d, q);
    endtask
    task automatic par(input logic [7:0] c, input logic [7:0] d);
        wr(1'b1, c);
        wr(1'b0, d);
        i_host.wait_ready();
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        reset = 1'b1;
        char_mode = 1'b1;
        repeat (3) @(posedge mclk);
        #1 reset = 1'b0;
        par(8'h09, 8'h12);
        par(8'h08, 8'h34);
        check("origin", 16'h1234, view_origin);
        par(8'h0a, 8'hff);
        par(8'h0b, 8'h00);
        check("cursor", 16'h00ff, cursor_addr);
        wr(1'b1, 8'h0c);
        wr(1'b0, 8'ha5);
        // The RAM write has long finished when the next access is taken
        i_host.access(1'b1, 1'b0, 8'h0c, q);
        i_host.access(1'b0, 1'b0, 8'h5a, q);
        i_host.wait_ready();
        check("cursor", 16'h0101, cursor_addr);
        par(8'h0a, 8'hff);
        par(8'h0b, 8'h00);
        par(8'h0e, 8'h02);
        par(8'h0f, 8'h07);
        check("cursor", 16'h0101, cursor_addr);
        par(8'h0a, 8'hff);
        par(8'h0b, 8'h00);
        wr(1'b1, 8'h0d);
        wr(1'b1, 8'h0d);
        i_host.access(1'b0, 1'b1, 8'h00, q);
        i_host.wait_ready();
        i_host.access(1'b0, 1'b1, 8'h00, q);
        check("ram", 16'h00a1, {8'h00, q});
        i_host.wait_ready();
        i_host.access(1'b0, 1'b1, 8'h00, q);
        check("ram", 16'h00da, {8'h00, q});
        i_host.wait_ready();
        check("cursor", 16'h0102, cursor_addr);
        wr(1'b1, 8'h09);
        i_host.access(1'b0, 1'b0, 8'h77, q);
        i_host.access(1'b1, 1'b1, 8'h00, q);
        check("status", 16'h0080, {8'h00, q});
        check("busy", 16'h0001, {15'h0000, busy});
        // Command and data taken while busy must both be dropped
        i_host.access(1'b1, 1'b0, 8'h0a, q);
        i_host.access(1'b0, 1'b0, 8'h66, q);
        i_host.wait_ready();
        check("origin", 16'h7734, view_origin);
        i_host.access(1'b0, 1'b0, 8'h34, q);
        i_host.wait_ready();
        check("origin", 16'h3434, view_origin);
        i_host.access(1'b1, 1'b0, 8'h0a, q);
        i_host.access(1'b1, 1'b1, 8'h00, q);
        check("status", 16'h0000, {8'h00, q});
        check("busy", 16'h0000, {15'h0000, busy});
        #1 char_mode = 1'b0;
        @(posedge mclk);
        #1;
        check("cursor", 16'h0000, cursor_addr);
        tally_and_finish();
    end
endmodule
